//--- tb/smfs_tx_model.sv
// Transmitter-side model: reference pulses, sampling phase and first-data marker
`timescale 1ns/10ps
module smfs_tx_model (
  input  wire logic        sys_clk_i,
  output logic             sysref_o,
  output logic [11:0]      sysref_phase_o,
  output logic             data_start_o
);
  int hold = 0;
  initial begin
    sysref_o       = 1'b0;
    sysref_phase_o = 12'h000;
    data_start_o   = 1'b0;
  end
  // Launched on a falling edge, so the pulse keeps a fixed phase to the clock
  task automatic fire(input logic [11:0] ph);
    sysref_o       = 1'b1;
    sysref_phase_o = ph;
    hold           = 4;
  endtask : fire
  // Held four cycles so the three-stage synchroniser cannot miss it
  always @(posedge sys_clk_i) begin
    if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 1) sysref_o <= 1'b0;
    end
  end
  // All lanes land together, so one marker stands for the whole link
  task automatic mark_start();
    data_start_o = 1'b1;
    @(negedge sys_clk_i);
    data_start_o = 1'b0;
  endtask : mark_start
endmodule : smfs_tx_model

//--- tb/tb.sv
// Self-checking bench for the multiframe sync block
`timescale 1ns/10ps
`include "smfs_cfg.svh"
module tb;
  import smfs_pkg::*;
  logic        sys_clk_i;
  logic        rst_i;
  smfs_req_s   req;
  logic [7:0]  rdata, v, h, d, s, e;
  logic        sref, dstart, lmfc, lnk, rel, jf;
  logic [11:0] ph, phin, st, pr;
  logic [3:0]  bdly;
  int          errors = 0, comparisons = 0, seed = 52445, cycles = 0, p, q, c;
  logic [1:0]  rmode [7] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  logic [7:0]  rjit [7]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1C, 8'h13, 8'h00};
  logic [6:0]  rsub = 7'h3F, rmov = 7'h25, rnew = 7'h77;
  logic [11:0] adr [4] = '{`SMFS_OFS_JITTER, `SMFS_OFS_DELAY, `SMFS_OFS_SPREAD, `SMFS_OFS_SUBC};

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  smfs_sync #(.OCTETS_PER_FRAME(2)) smfs_sync_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .sysref_i(sref), .sysref_phase_i(phin), .data_start_i(dstart), .lmfc_rx_o(lmfc),
    .link_enable_o(lnk), .rx_buffer_delay_o(bdly), .data_release_o(rel),
    .reference_jitter_flag_o(jf));
  smfs_tx_model smfs_tx_model_inst (.sys_clk_i(sys_clk_i), .sysref_o(sref),
    .sysref_phase_o(phin), .data_start_o(dstart));

  task automatic final_report();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      $display("Timeout after %0d cycles", cycles);
      final_report();
    end
  end

  function automatic logic [7:0] clamp(input logic [7:0] x);
    return (x > `SMFS_SPREAD_MAX) ? `SMFS_SPREAD_MAX : x;
  endfunction : clamp

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] dt);
    @(negedge sys_clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dt};
    @(negedge sys_clk_i);
    req = '0;
  endtask : wr

  // Sampled a cycle late on purpose: the read data holds until the next read
  task automatic rd(input logic [11:0] a, output logic [7:0] dt);
    @(negedge sys_clk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk_i);
    req = '0;
    @(negedge sys_clk_i);
    dt = rdata;
  endtask : rd

  task automatic wait_lmfc(output int n);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (lmfc !== 1'b1 && n < 40);
  endtask : wait_lmfc

  // Cycles from a reference pulse to the next local multiframe pulse, modulo the period
  task automatic gap(output int r);
    ph = 12'hFFF >> ($unsigned($random(seed)) % 12);
    smfs_tx_model_inst.fire(ph);
    r = 0;
    do begin
      @(negedge sys_clk_i);
      r++;
    end while (r < 8 || (lmfc !== 1'b1 && r < 60));
    r = r % 16;
  endtask : gap

  task automatic realign();
    wr(`SMFS_OFS_SUBC, 8'h20);
    wr(`SMFS_OFS_JITTER, 8'h00);
    wr(`SMFS_OFS_MODE, 8'h01);
    gap(q);
  endtask : realign

  initial begin
    req   = '0;
    rst_i = 1'b1;
    repeat (16) @(negedge sys_clk_i);
    rst_i = 1'b0;
    rd(12'h123, v);
    check(v, 12'h000);
    wr(`SMFS_OFS_LAT, 8'hFF);
    rd(`SMFS_OFS_LAT, v);
    check(v, 12'h000);
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], v);
      check(v, 12'h000);
      d = 8'($random(seed));
      wr(adr[i], d);
      rd(adr[i], v);
      check(v, (adr[i] == `SMFS_OFS_SPREAD) ? clamp(d) : d);
    end
    $display("Test registers done");
    // Start-up is taken as finished once reset is released
    wr(`SMFS_OFS_DELAY, 8'h00);
    realign();
    p = q;
    check(p, 12'h003);
    realign();
    check(q, p);
    for (int i = 0; i < 7; i++) begin
      if (rnew[i]) begin
        realign();
        wr(`SMFS_OFS_SUBC, {2'h0, rsub[i], 5'h00});
        wr(`SMFS_OFS_JITTER, rjit[i]);
        wr(`SMFS_OFS_MODE, 8'h00);
        wr(`SMFS_OFS_MODE, {6'h00, rmode[i]});
      end
      wr(`SMFS_OFS_STAT_LO, 8'h00);
      wait_lmfc(c);
      repeat ((21 - p) % 16) @(negedge sys_clk_i);
      gap(q);
      check(q == p, rmov[i]);
      if (rsub[i]) begin
        check(jf, rjit[i][5:2] < 4'h5);
        wr(`SMFS_OFS_STAT_LO, 8'h00);
        rd(`SMFS_OFS_STAT_LO, v);
        rd(`SMFS_OFS_STAT_HI, h);
        st = {h[3:0], v};
        check(st == 12'h000, rmov[i]);
        rd(`SMFS_OFS_PH_LO, v);
        rd(`SMFS_OFS_PH_HI, h);
        pr = {h[3:0], v};
        check(pr, ph);
      end
    end
    $display("Test alignment modes done");
    wr(`SMFS_OFS_PULSES, 8'h5A);
    for (int i = 0; i < 3; i++) gap(q);
    wr(`SMFS_OFS_STAT_LO, 8'h00);
    rd(`SMFS_OFS_PULSES, v);
    check(v, 12'h003);
    wr(`SMFS_OFS_PULSES, 8'hC3);
    wr(`SMFS_OFS_STAT_LO, 8'h00);
    rd(`SMFS_OFS_PULSES, v);
    check(v, 12'h000);
    $display("Test pulse count done");
    realign();
    wr(`SMFS_OFS_DELAY, 8'h05);
    gap(q);
    check(q, (p + 5) % 16);
    wait_lmfc(q);
    wait_lmfc(q);
    check(q, 12'h010);
    $display("Test multiframe offset done");
    for (int i = 0; i < 2; i++) begin
      d = 8'($unsigned($random(seed)) % 16);
      s = 8'($unsigned($random(seed)) % 16);
      e = clamp(s);
      wr(`SMFS_OFS_DELAY, d);
      wr(`SMFS_OFS_SPREAD, s);
      rd(`SMFS_OFS_SPREAD, v);
      check(v, e);
      wr(`SMFS_OFS_LINK, 8'h01);
      @(negedge sys_clk_i);
      check({lnk, bdly}, {1'b1, e[3:0]});
      wait_lmfc(q);
      c = 2 + $unsigned($random(seed)) % 11;
      repeat (c) @(negedge sys_clk_i);
      smfs_tx_model_inst.mark_start();
      wait_lmfc(q);
      q = 0;
      while (rel !== 1'b1 && q < 40) begin
        @(negedge sys_clk_i);
        q++;
      end
      check(q, e + 2);
      rd(`SMFS_OFS_LAT, v);
      check(v, c);
      wr(`SMFS_OFS_LINK, 8'h00);
      @(negedge sys_clk_i);
      check({lnk, rel}, 12'h000);
    end
    $display("Test link bring-up done");
    final_report();
  end
endmodule : tb

//--- verilog/smfs_cfg.svh
// Constants of the multiframe sync block
`ifndef SMFS_CFG_SVH
`define SMFS_CFG_SVH
`define SMFS_OFS_STAT_LO 12'h034
`define SMFS_OFS_STAT_HI 12'h035
`define SMFS_OFS_PULSES  12'h036
`define SMFS_OFS_PH_LO   12'h037
`define SMFS_OFS_PH_HI   12'h038
`define SMFS_OFS_JITTER  12'h039
`define SMFS_OFS_MODE    12'h03A
`define SMFS_OFS_LINK    12'h300
`define SMFS_OFS_LAT     12'h302
`define SMFS_OFS_DELAY   12'h304
`define SMFS_OFS_SPREAD  12'h306
`define SMFS_OFS_SUBC    12'h458
`define SMFS_MODE_MON    2'h0
`define SMFS_MODE_CONT   2'h1
`define SMFS_MODE_ONCE   2'h2
`define SMFS_SUBC_MSB    7
`define SMFS_SUBC_LSB    5
`define SMFS_SUBC_ONE    3'h1
`define SMFS_JIT_MSB     5
`define SMFS_JIT_LSB     2
`define SMFS_SPREAD_MAX  8'h0A
`define SMFS_K_FRAMES    32
`define SMFS_OCT_PER_CYC 4
`define SMFS_LINK_EN_BIT 0
`endif

//--- verilog/smfs_pkg.sv
// Types shared by the multiframe sync block
`include "smfs_cfg.svh"
package smfs_pkg;
  typedef enum logic [4:0] {
    SMFS_LNK_IDLE = 5'h01,
    SMFS_LNK_WAIT = 5'h02,
    SMFS_LNK_LMFC = 5'h04,
    SMFS_LNK_HOLD = 5'h08,
    SMFS_LNK_RUN  = 5'h10
  } smfs_link_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } smfs_req_s;

  typedef struct packed {
    logic        sref_s1, sref_s2, sref_s3;
    logic [11:0] ph_s1, ph_s2, phase_snap, stat_live, stat_hold;
    logic [7:0]  jit, mode, link, del, spread, subc;
    logic        armed, jflag, lmfc_rx, drain;
    logic [7:0]  lmfc_cnt, pulse_cnt, cnt_hold, since_rx, lat, rdata;
    logic [3:0]  dly;
    smfs_link_e  st;
  } smfs_state_s;
endpackage : smfs_pkg

//--- verilog/smfs_sync.sv
// Multiframe clock sync, delayed local multiframe clock and link release
`timescale 1ns/10ps
`include "smfs_cfg.svh"
module smfs_sync #(
  parameter int OCTETS_PER_FRAME = 2
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire smfs_pkg::smfs_req_s reg_req_i,
  output logic [7:0]             reg_rdata_o,
  input  wire logic              sysref_i,
  input  wire logic [11:0]       sysref_phase_i,
  input  wire logic              data_start_i,
  output logic                   lmfc_rx_o,
  output logic                   link_enable_o,
  output logic [3:0]             rx_buffer_delay_o,
  output logic                   data_release_o,
  output logic                   reference_jitter_flag_o
);
  import smfs_pkg::*;

  localparam int PER_I = `SMFS_K_FRAMES * OCTETS_PER_FRAME / `SMFS_OCT_PER_CYC;
  localparam logic [7:0] PER = 8'(PER_I);
  localparam logic [7:0] HALF = 8'(PER_I / 2);
  localparam smfs_state_s RST_STATE = '{st: SMFS_LNK_IDLE, default: '0};

  generate
    if (OCTETS_PER_FRAME != 1 && OCTETS_PER_FRAME != 2 &&
        OCTETS_PER_FRAME != 4) begin : g_bad_f
      $error("OCTETS_PER_FRAME must be 1, 2 or 4");
    end
  endgenerate

  function automatic logic hit(input smfs_req_s r, input logic [11:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  smfs_state_s s;
  smfs_state_s n;

  logic       edge_w;
  logic       subc1_w;
  logic       align_w;
  logic       check_w;
  logic       adjust_w;
  logic       ok_w;
  logic [7:0] win_w;
  logic [7:0] dist_w;
  logic [7:0] del_m_w;
  logic [1:0] mode_w;
  logic       link_on_w;

  // The second and third sync stages feed the edge detector
  assign edge_w    = s.sref_s2 & ~s.sref_s3;
  assign subc1_w   = s.subc[`SMFS_SUBC_MSB:`SMFS_SUBC_LSB] == `SMFS_SUBC_ONE;
  // Subclass 0 never aligns to the reference input; its edges are still counted
  assign align_w   = edge_w & subc1_w;
  assign mode_w    = s.mode[1:0];
  assign check_w   = align_w &&
                     ((mode_w == `SMFS_MODE_CONT) ||
                      ((mode_w == `SMFS_MODE_ONCE) && s.armed));
  // Low two bits dropped: the window resolves whole quarter-rate cycles
  assign win_w     = {4'h0, s.jit[`SMFS_JIT_MSB:`SMFS_JIT_LSB]};
  assign dist_w    = (s.lmfc_cnt > HALF) ? PER - s.lmfc_cnt : s.lmfc_cnt;
  assign ok_w      = dist_w <= win_w;
  assign adjust_w  = check_w & ~ok_w;
  // Offset wraps on the multiframe period, a power of two
  assign del_m_w   = s.del & (PER - 8'h01);
  assign link_on_w = s.link[`SMFS_LINK_EN_BIT];

  always_comb begin : nxt_logic
    n = s;
    n.sref_s1 = sysref_i;
    n.sref_s2 = s.sref_s1;
    n.sref_s3 = s.sref_s2;
    n.ph_s1   = sysref_phase_i;
    n.ph_s2   = s.ph_s1;

    if (hit(reg_req_i, `SMFS_OFS_JITTER)) begin
      n.jit = reg_req_i.wdata;
    end
    if (hit(reg_req_i, `SMFS_OFS_LINK)) begin
      n.link = reg_req_i.wdata;
    end
    if (hit(reg_req_i, `SMFS_OFS_DELAY)) begin
      n.del = reg_req_i.wdata;
    end
    if (hit(reg_req_i, `SMFS_OFS_SUBC)) begin
      n.subc = reg_req_i.wdata;
    end
    // Values beyond the buffer depth are clamped so readback shows what is used
    if (hit(reg_req_i, `SMFS_OFS_SPREAD)) begin
      n.spread = (reg_req_i.wdata > `SMFS_SPREAD_MAX) ? `SMFS_SPREAD_MAX
                                                      : reg_req_i.wdata;
    end

    // Arming needs a change into one-shot, so an old setting must be cleared
    if (check_w) begin
      n.armed = 1'b0;
    end
    if (hit(reg_req_i, `SMFS_OFS_MODE)) begin
      n.mode  = reg_req_i.wdata;
      n.armed = (reg_req_i.wdata[1:0] == `SMFS_MODE_ONCE) &&
                (mode_w != `SMFS_MODE_ONCE);
    end

    // Multiframe counter in processing cycles; a realignment makes this edge
    // the boundary, so the following cycle is position one
    if (adjust_w) begin
      n.lmfc_cnt = 8'h01;
    end else if (s.lmfc_cnt >= PER - 8'h01) begin
      n.lmfc_cnt = 8'h00;
    end else begin
      n.lmfc_cnt = s.lmfc_cnt + 8'h01;
    end
    n.lmfc_rx = (s.lmfc_cnt == del_m_w);

    // Phase error is kept in device clocks, four per processing cycle
    if (align_w) begin
      n.phase_snap = s.ph_s2;
      n.stat_live  = adjust_w ? 12'h000
                              : {2'h0, s.lmfc_cnt, 2'h0};
    end

    if (hit(reg_req_i, `SMFS_OFS_STAT_LO)) begin
      n.stat_hold = s.stat_live;
      n.cnt_hold  = s.pulse_cnt;
      n.jflag     = 1'b0;
    end
    // A jitter event in the clearing cycle survives
    if (align_w && !ok_w) begin
      n.jflag = 1'b1;
    end

    // Counter saturates; an edge in the clearing cycle counts as one
    if (hit(reg_req_i, `SMFS_OFS_PULSES)) begin
      n.pulse_cnt = 8'h00;
    end
    if (edge_w) begin
      if (hit(reg_req_i, `SMFS_OFS_PULSES)) begin
        n.pulse_cnt = 8'h01;
      end else if (s.pulse_cnt != 8'hFF) begin
        n.pulse_cnt = s.pulse_cnt + 8'h01;
      end
    end

    if (s.lmfc_rx) begin
      n.since_rx = 8'h01;
    end else if (s.since_rx != 8'hFF) begin
      n.since_rx = s.since_rx + 8'h01;
    end

    unique case (s.st)
      SMFS_LNK_IDLE: begin
        if (link_on_w) begin
          n.st = SMFS_LNK_WAIT;
        end
      end
      SMFS_LNK_WAIT: begin
        if (data_start_i) begin
          n.lat = s.lmfc_rx ? 8'h00 : s.since_rx;
          n.st  = SMFS_LNK_LMFC;
        end
      end
      SMFS_LNK_LMFC: begin
        if (s.lmfc_rx) begin
          n.dly = s.spread[3:0];
          n.st  = SMFS_LNK_HOLD;
        end
      end
      SMFS_LNK_HOLD: begin
        if (s.dly == 4'h0) begin
          n.drain   = 1'b1;
          n.st      = SMFS_LNK_RUN;
        end else begin
          n.dly = s.dly - 4'h1;
        end
      end
      SMFS_LNK_RUN: begin
        n.drain = 1'b1;
      end
    endcase
    if (!link_on_w) begin
      n.st      = SMFS_LNK_IDLE;
      n.drain   = 1'b0;
    end

    // Read data is registered: answer one cycle after the strobe
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `SMFS_OFS_STAT_LO: n.rdata = s.stat_hold[7:0];
        `SMFS_OFS_STAT_HI: n.rdata = {s.jflag, 3'h0, s.stat_hold[11:8]};
        `SMFS_OFS_PULSES:  n.rdata = s.cnt_hold;
        `SMFS_OFS_PH_LO:   n.rdata = s.phase_snap[7:0];
        `SMFS_OFS_PH_HI:   n.rdata = {4'h0, s.phase_snap[11:8]};
        `SMFS_OFS_JITTER:  n.rdata = s.jit;
        `SMFS_OFS_MODE:    n.rdata = s.mode;
        `SMFS_OFS_LINK:    n.rdata = s.link;
        `SMFS_OFS_LAT:     n.rdata = s.lat;
        `SMFS_OFS_DELAY:   n.rdata = s.del;
        `SMFS_OFS_SPREAD:  n.rdata = s.spread;
        `SMFS_OFS_SUBC:    n.rdata = s.subc;
        default:           n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin : state_reg
    if (rst_i) begin
      s <= RST_STATE;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_o             = s.rdata;
  assign lmfc_rx_o               = s.lmfc_rx;
  assign link_enable_o           = link_on_w;
  assign rx_buffer_delay_o       = s.spread[3:0];
  assign data_release_o          = s.drain;
  assign reference_jitter_flag_o = s.jflag;

  // Helper for the assertions: cycles spent in the hold state
  logic [4:0] hold_cyc;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin : hold_meter
    if (rst_i) begin
      hold_cyc <= 5'h00;
    end else if (s.st == SMFS_LNK_HOLD) begin
      hold_cyc <= hold_cyc + 5'h01;
    end else begin
      hold_cyc <= 5'h00;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_count_clear;
    hit(reg_req_i, `SMFS_OFS_PULSES) && !edge_w;
  endsequence

  sequence s_misaligned_cont;
    align_w && !ok_w && (mode_w == `SMFS_MODE_CONT);
  endsequence

  sequence s_aligned_mid;
    align_w && ok_w && (s.lmfc_cnt < PER - 8'h01);
  endsequence

  chk_pulse_clear: assert property (s_count_clear |=> s.pulse_cnt == 8'h00)
    else $error("pulse count not cleared by write");

  chk_snap_count: assert property (
    hit(reg_req_i, `SMFS_OFS_STAT_LO) |=> s.cnt_hold == $past(s.pulse_cnt))
    else $error("pulse count not captured by status write");

  chk_cont_realign: assert property (
    s_misaligned_cont |=> (s.lmfc_cnt == 8'h01) ##1 (s.lmfc_cnt == 8'h02))
    else $error("continuous mode did not realign the counter");

  chk_oneshot_once: assert property (
    (check_w && mode_w == `SMFS_MODE_ONCE && !hit(reg_req_i, `SMFS_OFS_MODE))
    |=> !s.armed)
    else $error("one-shot stayed armed after alignment");

  chk_aligned_keep: assert property (
    s_aligned_mid |=> s.lmfc_cnt == $past(s.lmfc_cnt) + 8'h01)
    else $error("aligned edge moved the counter phase");

  chk_lmfc_offset: assert property (
    lmfc_rx_o |-> $past(s.lmfc_cnt) == $past(del_m_w))
    else $error("local multiframe pulse off the programmed offset");

  chk_spread_limit: assert property (
    rx_buffer_delay_o <= `SMFS_SPREAD_MAX)
    else $error("buffer delay above ten cycles");

  chk_release_delay: assert property (
    $rose(data_release_o) |-> hold_cyc == $past(s.spread[4:0]) + 5'h01)
    else $error("release not spread cycles after local boundary");

  chk_link_off: assert property (
    !link_enable_o |=> (s.st == SMFS_LNK_IDLE) && !data_release_o)
    else $error("link kept running while disabled");

  chk_jitter_flag: assert property (
    align_w && !ok_w |=> reference_jitter_flag_o)
    else $error("jitter flag not raised on misaligned edge");

  chk_phase_snap: assert property (
    align_w |=> s.phase_snap == $past(s.ph_s2))
    else $error("sampling phase not captured on reference edge");

  chk_sub0_ignore: assert property (
    (!subc1_w && edge_w) |=> $stable(s.phase_snap))
    else $error("subclass 0 reacted to reference edge");

  // Monitor mode reports the phase but never moves the counter
  sequence s_monitor_edge;
    align_w && (mode_w == `SMFS_MODE_MON) && (s.lmfc_cnt < PER - 8'h01);
  endsequence

  chk_monitor_hold: assert property (
    s_monitor_edge |=> s.lmfc_cnt == $past(s.lmfc_cnt) + 8'h01)
    else $error("monitor mode moved the counter phase");

  chk_oneshot_move: assert property (
    check_w && (mode_w == `SMFS_MODE_ONCE) && !ok_w |=> s.lmfc_cnt == 8'h01)
    else $error("armed one-shot did not realign the counter");

  chk_count_step: assert property (
    edge_w && !hit(reg_req_i, `SMFS_OFS_PULSES) && (s.pulse_cnt != 8'hFF)
    |=> s.pulse_cnt == $past(s.pulse_cnt) + 8'h01)
    else $error("reference pulse not counted");

  chk_status_snap: assert property (
    hit(reg_req_i, `SMFS_OFS_STAT_LO) |=> s.stat_hold == $past(s.stat_live))
    else $error("alignment status not captured by status write");

  chk_status_value: assert property (
    align_w && ok_w |=> s.stat_live == {2'h0, $past(s.lmfc_cnt), 2'h0})
    else $error("aligned edge status not in device clocks");

  chk_flag_clear: assert property (
    hit(reg_req_i, `SMFS_OFS_STAT_LO) && !(align_w && !ok_w) |=> !reference_jitter_flag_o)
    else $error("jitter flag not cleared by status write");

  chk_link_wait: assert property (
    (s.st == SMFS_LNK_IDLE) && link_on_w |=> s.st == SMFS_LNK_WAIT)
    else $error("enabled link did not leave idle");

  chk_lat_capture: assert property (
    (s.st == SMFS_LNK_WAIT) && data_start_i && link_on_w
    |=> s.lat == ($past(s.lmfc_rx) ? 8'h00 : $past(s.since_rx)))
    else $error("link latency not captured at first data");

  chk_hold_load: assert property (
    (s.st == SMFS_LNK_LMFC) && s.lmfc_rx && link_on_w
    |=> (s.st == SMFS_LNK_HOLD) && (s.dly == $past(s.spread[3:0])))
    else $error("buffer delay not loaded at local boundary");

  chk_release_hold: assert property (
    data_release_o && link_enable_o |=> data_release_o)
    else $error("release dropped while link enabled");
endmodule : smfs_sync
